// ### core/lrs_defs.vh
// Constants for the rotate, skip and logic execute datapath
`ifndef LRS_DEFS_VH
`define LRS_DEFS_VH

// ****************************************
// Operation codes
// ****************************************
`define LRS_OP_NOP    5'h00
`define LRS_OP_ORA    5'h01
`define LRS_OP_ORI    5'h02
`define LRS_OP_ORM    5'h03
`define LRS_OP_RETS   5'h04
`define LRS_OP_RETL   5'h05
`define LRS_OP_INTERRUPT_EXIT   5'h06
`define LRS_OP_ROL    5'h07
`define LRS_OP_ROLC   5'h08
`define LRS_OP_ROR    5'h09
`define LRS_OP_RORC   5'h0a
`define LRS_OP_SBCA   5'h0b
`define LRS_OP_SBCM   5'h0c
`define LRS_OP_SUBA   5'h0d
`define LRS_OP_SUBI   5'h0e
`define LRS_OP_SUBM   5'h0f
`define LRS_OP_DECSK  5'h10
`define LRS_OP_INCSK  5'h11
`define LRS_OP_BITSK  5'h12
`define LRS_OP_SETB   5'h13
`define LRS_OP_SETBIT 5'h14
`define LRS_OP_SWAPN  5'h15

// ****************************************
// Widths, reset values and the all-ones set-byte value
// ****************************************
`define LRS_PC_W      13
`define LRS_ACC_RST   8'h00
`define LRS_ALL_ONES  8'hff

// ****************************************
// Sequencer states
// ****************************************
`define LRS_ST_RUN    1'b0
`define LRS_ST_DUMMY  1'b1

`endif

// ### core/lrs_exec.v
// Execute datapath for logic, rotate, subtract, skip and return instructions
`timescale 1ns/1ps
`default_nettype none
`include "lrs_defs.vh"

module lrs_exec (
    input  wire                    clk,
    input  wire                    sys_rst,
    input  wire                    clk_en,
    input  wire                    instr_valid,
    input  wire [4:0]              op_code,
    input  wire                    to_acc,
    input  wire [2:0]              bit_sel,
    input  wire [7:0]              imm_byte,
    input  wire [7:0]              mem_rdata,
    input  wire [`LRS_PC_W-1:0]    stack_top,
    input  wire                    irq_pending,
    output reg  [7:0]              working_register,
    output reg                     carry_flag,
    output reg                     zero_flag,
    output reg                     half_carry_flag,
    output reg                     signed_wrap_flag,
    output reg                     global_interrupt_enable,
    output reg                     mem_we,
    output reg  [7:0]              mem_wdata,
    output reg                     stack_pop,
    output reg                     pc_load,
    output reg  [`LRS_PC_W-1:0]    pc_value,
    output reg                     pc_advance,
    output reg                     skip_dummy,
    output reg                     irq_service
);

    // ****************************************
    // State
    // ****************************************
    localparam ST_RUN   = 1'b0;
    localparam ST_DUMMY = 1'b1;

    reg       state;
    reg       next_state;

    reg [7:0] next_acc;
    reg       next_c;
    reg       next_z;
    reg       next_ac;
    reg       next_ov;
    reg       next_gie;
    reg       next_we;
    reg [7:0] next_wdata;
    reg       next_pop;
    reg       next_pc_load;
    reg       next_adv;
    reg       next_dummy;
    reg       next_irq;

    // ****************************************
    // Arithmetic helpers
    // ****************************************
    wire       sub_borrow_in = ((op_code == `LRS_OP_SBCA) || (op_code == `LRS_OP_SBCM)) ? ~carry_flag : 1'b0;
    wire [7:0] sub_rhs       = (op_code == `LRS_OP_SUBI) ? imm_byte : mem_rdata;
    wire [8:0] sub_full      = {1'b0, working_register} - {1'b0, sub_rhs} - {8'h00, sub_borrow_in};
    wire [4:0] sub_low       = {1'b0, working_register[3:0]} - {1'b0, sub_rhs[3:0]} - {4'h0, sub_borrow_in};
    wire [7:0] sub_res       = sub_full[7:0];
    wire       sub_ov        = (working_register[7] ^ sub_rhs[7]) & (working_register[7] ^ sub_res[7]);
    wire [7:0] or_rhs        = (op_code == `LRS_OP_ORI) ? imm_byte : mem_rdata;
    wire [7:0] or_res        = working_register | or_rhs;
    wire [7:0] dec_res       = mem_rdata - 8'h01;
    wire [7:0] inc_res       = mem_rdata + 8'h01;
    wire [7:0] bit_mask      = 8'h01 << bit_sel;

    // ****************************************
    // Next-state decode
    // ****************************************
    always @* begin
        next_state   = ST_RUN;
        next_acc     = working_register;
        next_c       = carry_flag;
        next_z       = zero_flag;
        next_ac      = half_carry_flag;
        next_ov      = signed_wrap_flag;
        next_gie     = global_interrupt_enable;
        next_we      = 1'b0;
        next_wdata   = mem_wdata;
        next_pop     = 1'b0;
        next_pc_load = 1'b0;
        next_adv     = 1'b0;
        next_dummy   = 1'b0;
        next_irq     = 1'b0;
        if (state == ST_DUMMY) begin
            // Skipped instruction is discarded, fetch moves past it
            next_dummy = 1'b1;
            next_adv   = 1'b1;
        end else if (instr_valid) begin
            next_adv = 1'b1;
            case (op_code)
                `LRS_OP_NOP: begin
                    next_adv = 1'b1;
                end
                `LRS_OP_ORA, `LRS_OP_ORI: begin
                    next_acc = or_res;
                    next_z   = (or_res == 8'h00);
                end
                `LRS_OP_ORM: begin
                    next_we    = 1'b1;
                    next_wdata = or_res;
                    next_z     = (or_res == 8'h00);
                end
                `LRS_OP_RETS, `LRS_OP_RETL, `LRS_OP_INTERRUPT_EXIT: begin
                    next_pop     = 1'b1;
                    next_pc_load = 1'b1;
                    next_adv     = 1'b0;
                    if (op_code == `LRS_OP_RETL) begin
                        next_acc = imm_byte;
                    end
                    if (op_code == `LRS_OP_INTERRUPT_EXIT) begin
                        next_gie = 1'b1;
                        next_irq = irq_pending;
                    end
                end
                `LRS_OP_ROL, `LRS_OP_ROLC, `LRS_OP_ROR, `LRS_OP_RORC: begin
                    case (op_code)
                        `LRS_OP_ROL:  next_wdata = {mem_rdata[6:0], mem_rdata[7]};
                        `LRS_OP_ROLC: next_wdata = {mem_rdata[6:0], carry_flag};
                        `LRS_OP_ROR:  next_wdata = {mem_rdata[0], mem_rdata[7:1]};
                        default:      next_wdata = {carry_flag, mem_rdata[7:1]};
                    endcase
                    if (op_code == `LRS_OP_ROLC) begin
                        next_c = mem_rdata[7];
                    end
                    if (op_code == `LRS_OP_RORC) begin
                        next_c = mem_rdata[0];
                    end
                    if (to_acc) begin
                        next_acc   = next_wdata;
                        next_wdata = mem_wdata;
                    end else begin
                        next_we = 1'b1;
                    end
                end
                `LRS_OP_SBCA, `LRS_OP_SBCM, `LRS_OP_SUBA, `LRS_OP_SUBI, `LRS_OP_SUBM: begin
                    next_c  = ~sub_full[8];
                    next_z  = (sub_res == 8'h00);
                    next_ac = ~sub_low[4];
                    next_ov = sub_ov;
                    if ((op_code == `LRS_OP_SBCM) || (op_code == `LRS_OP_SUBM)) begin
                        next_we    = 1'b1;
                        next_wdata = sub_res;
                    end else begin
                        next_acc = sub_res;
                    end
                end
                `LRS_OP_DECSK, `LRS_OP_INCSK: begin
                    if (to_acc) begin
                        next_acc = (op_code == `LRS_OP_DECSK) ? dec_res : inc_res;
                    end else begin
                        next_we    = 1'b1;
                        next_wdata = (op_code == `LRS_OP_DECSK) ? dec_res : inc_res;
                    end
                    if (((op_code == `LRS_OP_DECSK) ? dec_res : inc_res) == 8'h00) begin
                        next_state = ST_DUMMY;
                    end
                end
                `LRS_OP_BITSK: begin
                    if ((mem_rdata & bit_mask) != 8'h00) begin
                        next_state = ST_DUMMY;
                    end
                end
                `LRS_OP_SETB: begin
                    next_we    = 1'b1;
                    next_wdata = `LRS_ALL_ONES;
                end
                `LRS_OP_SETBIT: begin
                    next_we    = 1'b1;
                    next_wdata = mem_rdata | bit_mask;
                end
                `LRS_OP_SWAPN: begin
                    next_we    = 1'b1;
                    next_wdata = {mem_rdata[3:0], mem_rdata[7:4]};
                end
                default: begin
                    next_adv = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Sequencer state
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_RUN;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // ****************************************
    // Working register
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            working_register <= `LRS_ACC_RST;
        end else if (clk_en) begin
            working_register <= next_acc;
        end
    end

    // ****************************************
    // Carry flag
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            carry_flag <= 1'b0;
        end else if (clk_en) begin
            carry_flag <= next_c;
        end
    end

    // ****************************************
    // Zero flag
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            zero_flag <= 1'b0;
        end else if (clk_en) begin
            zero_flag <= next_z;
        end
    end

    // ****************************************
    // Half carry flag
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            half_carry_flag <= 1'b0;
        end else if (clk_en) begin
            half_carry_flag <= next_ac;
        end
    end

    // ****************************************
    // Signed wrap flag
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            signed_wrap_flag <= 1'b0;
        end else if (clk_en) begin
            signed_wrap_flag <= next_ov;
        end
    end

    // ****************************************
    // Global interrupt enable
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            global_interrupt_enable <= 1'b0;
        end else if (clk_en) begin
            global_interrupt_enable <= next_gie;
        end
    end

    // ****************************************
    // Data memory write
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            mem_we    <= 1'b0;
            mem_wdata <= 8'h00;
        end else if (clk_en) begin
            mem_we    <= next_we;
            mem_wdata <= next_wdata;
        end
    end

    // ****************************************
    // Stack pop and program counter load
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            stack_pop <= 1'b0;
            pc_load   <= 1'b0;
        end else if (clk_en) begin
            stack_pop <= next_pop;
            pc_load   <= next_pc_load;
        end
    end

    // ****************************************
    // Restored program counter
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            pc_value <= {`LRS_PC_W{1'b0}};
        end else if (clk_en && next_pc_load) begin
            pc_value <= stack_top;
        end
    end

    // ****************************************
    // Sequencer pulses
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            pc_advance  <= 1'b0;
            skip_dummy  <= 1'b0;
            irq_service <= 1'b0;
        end else if (clk_en) begin
            pc_advance  <= next_adv;
            skip_dummy  <= next_dummy;
            irq_service <= next_irq;
        end
    end

endmodule

`default_nettype wire

// ### sim/lrs_exec_props.sv
// Checker for the execute datapath outputs
`timescale 1ns/1ps
`default_nettype none
`include "lrs_defs.vh"
module lrs_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic        instr_valid,
    input wire logic [4:0]  op_code,
    input wire logic        to_acc,
    input wire logic [7:0]  mem_rdata,
    input wire logic [12:0] stack_top,
    input wire logic        irq_pending,
    input wire logic [7:0]  working_register,
    input wire logic        carry_flag,
    input wire logic        zero_flag,
    input wire logic        global_interrupt_enable,
    input wire logic        mem_we,
    input wire logic [7:0]  mem_wdata,
    input wire logic        stack_pop,
    input wire logic        pc_load,
    input wire logic [12:0] pc_value,
    input wire logic        pc_advance,
    input wire logic        skip_dummy,
    input wire logic        irq_service
);
    // ****************************************
    // Properties
    // ****************************************
    wire go = clk_en && instr_valid;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    nop_quiet_a: assert property (
        go && op_code == `LRS_OP_NOP |=> skip_dummy || (pc_advance && !mem_we && $stable(working_register)))
        else $error("nop changed state");
    or_mem_a: assert property (
        go && op_code == `LRS_OP_ORM |=> skip_dummy || (mem_we && zero_flag == (mem_wdata == 8'h00)
        && mem_wdata == ($past(working_register) | $past(mem_rdata)))) else $error("or to memory wrong");
    ret_pc_a: assert property (
        go && (op_code == `LRS_OP_RETS || op_code == `LRS_OP_RETL) |=> skip_dummy
        || (pc_load && stack_pop && !pc_advance && pc_value == $past(stack_top))) else $error("return pc wrong");
    interrupt_exit_gie_a: assert property (
        go && op_code == `LRS_OP_INTERRUPT_EXIT |=> skip_dummy || (global_interrupt_enable && pc_load
        && irq_service == $past(irq_pending))) else $error("interrupt exit wrong");
    rol_flags_a: assert property (
        go && op_code == `LRS_OP_ROL |=> skip_dummy || ($stable(carry_flag) && $stable(zero_flag)))
        else $error("rotate changed flags");
    dec_mem_a: assert property (
        go && op_code == `LRS_OP_DECSK && !to_acc |=> skip_dummy || (mem_we
        && mem_wdata == $past(mem_rdata) - 8'h01)) else $error("decrement write wrong");
    swap_nib_a: assert property (
        go && op_code == `LRS_OP_SWAPN |=> skip_dummy || (mem_we
        && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})) else $error("swap wrong");
    dummy_quiet_a: assert property (
        skip_dummy |-> pc_advance && !mem_we && !pc_load ##1 (!$past(clk_en) || !skip_dummy))
        else $error("dummy cycle wrong");
    skip_seen_c: cover property (skip_dummy);
    irq_seen_c: cover property (irq_service);
    ret_seen_c: cover property (pc_load);
endmodule
bind lrs_exec lrs_props u_props (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .instr_valid(instr_valid),
    .op_code(op_code), .to_acc(to_acc), .mem_rdata(mem_rdata), .stack_top(stack_top),
    .irq_pending(irq_pending), .working_register(working_register), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .global_interrupt_enable(global_interrupt_enable), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
    .pc_advance(pc_advance), .skip_dummy(skip_dummy), .irq_service(irq_service));
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the execute datapath
`timescale 1ns/1ps
`default_nettype none
`include "lrs_defs.vh"
module tb_top;
    // ****************************************
    // Stimulus, model and checks
    // ****************************************
    logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0, to_acc = 1'b0;
    logic        irq_pending = 1'b0, en_d = 1'b0, c = 1'b0, z = 1'b0, h = 1'b0, v = 1'b0, gie = 1'b0, skp = 1'b0;
    logic [4:0]  op_code = 5'h00;
    logic [2:0]  bit_sel = 3'h0;
    logic [7:0]  imm_byte = 8'h00, mem_rdata = 8'h00, acc = 8'h00, wd = 8'h00, r, working_register, mem_wdata;
    logic [12:0] stack_top = 13'h0000, pcv = 13'h0000, pc_value;
    logic        carry_flag, zero_flag, half_carry_flag, signed_wrap_flag, global_interrupt_enable;
    logic        mem_we, stack_pop, pc_load, pc_advance, skip_dummy, irq_service;
    logic [39:0] q[$];
    int          failures = 0, cmp_count = 0, cyc = 0;
    lrs_exec uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .instr_valid(instr_valid), .op_code(op_code),
        .to_acc(to_acc), .bit_sel(bit_sel), .imm_byte(imm_byte), .mem_rdata(mem_rdata), .stack_top(stack_top),
        .irq_pending(irq_pending), .working_register(working_register), .carry_flag(carry_flag),
        .zero_flag(zero_flag), .half_carry_flag(half_carry_flag), .signed_wrap_flag(signed_wrap_flag),
        .global_interrupt_enable(global_interrupt_enable), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value), .pc_advance(pc_advance),
        .skip_dummy(skip_dummy), .irq_service(irq_service));
    always #12.5 clk = ~clk;
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(input logic en, input logic val);
        logic [31:0] x;
        logic [7:0]  m, s;
        logic [8:0]  d;
        logic [4:0]  n;
        logic        we, sp, pl, ad, dm, sk, wr, tt, bn, irs;
        x = $urandom;
        m = $urandom;
        if (m[7:6] == 2'b00) m = {8{m[0]}} ^ {7'h00, m[1]};
        @(posedge clk);
        {clk_en, instr_valid, op_code, to_acc, bit_sel, imm_byte, mem_rdata, stack_top, irq_pending} <=
            {en, val, x[4:0] % 5'd23, x[16:5], m, x[29:17], x[30]};
        #1;
        {we, sp, pl, ad, dm, sk, wr, tt, bn, irs} = 10'b0001000000;
        if (en) begin
            if (skp) begin
                {dm, skp} = 2'b10;
            end else if (val) begin
                case (op_code)
                    `LRS_OP_ORA: {acc, z} = {acc | m, (acc | m) == 8'h00};
                    `LRS_OP_ORI: {acc, z} = {acc | imm_byte, (acc | imm_byte) == 8'h00};
                    `LRS_OP_ORM: {we, wd, z} = {1'b1, acc | m, (acc | m) == 8'h00};
                    `LRS_OP_RETS: {sp, pl, ad, pcv} = {3'b110, stack_top};
                    `LRS_OP_RETL: {sp, pl, ad, pcv, acc} = {3'b110, stack_top, imm_byte};
                    `LRS_OP_INTERRUPT_EXIT: {sp, pl, ad, pcv, gie, irs} = {3'b110, stack_top, 1'b1, irq_pending};
                    `LRS_OP_ROL: {wr, tt, r} = {1'b1, to_acc, m[6:0], m[7]};
                    `LRS_OP_ROLC: {wr, tt, c, r} = {1'b1, to_acc, m, c};
                    `LRS_OP_ROR: {wr, tt, r} = {1'b1, to_acc, m[0], m[7:1]};
                    `LRS_OP_RORC: {wr, tt, r, c} = {1'b1, to_acc, c, m};
                    `LRS_OP_DECSK: {wr, tt, r, sk} = {1'b1, to_acc, m - 8'h01, m == 8'h01};
                    `LRS_OP_INCSK: {wr, tt, r, sk} = {1'b1, to_acc, m + 8'h01, m == 8'hff};
                    `LRS_OP_BITSK: sk = m[bit_sel];
                    `LRS_OP_SETB: {we, wd} = {1'b1, 8'hff};
                    `LRS_OP_SETBIT: {we, wd} = {1'b1, m | (8'h01 << bit_sel)};
                    `LRS_OP_SWAPN: {we, wd} = {1'b1, m[3:0], m[7:4]};
                    `LRS_OP_SBCA, `LRS_OP_SBCM, `LRS_OP_SUBA, `LRS_OP_SUBI, `LRS_OP_SUBM: begin
                        s = (op_code == `LRS_OP_SUBI) ? imm_byte : m;
                        bn = (op_code == `LRS_OP_SBCA || op_code == `LRS_OP_SBCM) && !c;
                        d = {1'b0, acc} - s - bn;
                        n = {1'b0, acc[3:0]} - s[3:0] - bn;
                        v = (acc[7] != s[7]) && (d[7] != acc[7]);
                        {wr, tt, r, c, h, z} = {1'b1, op_code != `LRS_OP_SBCM && op_code != `LRS_OP_SUBM,
                            d[7:0], !d[8], !n[4], d[7:0] == 8'h00};
                    end
                    default: ;
                endcase
                if (wr && tt) acc = r;
                if (wr && !tt) {we, wd} = {1'b1, r};
                skp = sk;
            end
            if (dm || val) q.push_back({acc, c, z, h, v, gie, we, wd, sp, pl, pcv, ad, dm, irs});
        end
    endtask
    always @(posedge clk) begin
        en_d <= clk_en && !sys_rst;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures = failures + 1;
            results();
        end
    end
    always @(negedge clk) begin
        if (en_d && (pc_advance === 1'b1 || pc_load === 1'b1)) begin
            chk("outputs", {working_register, carry_flag, zero_flag, half_carry_flag, signed_wrap_flag,
                global_interrupt_enable, mem_we, mem_wdata, stack_pop, pc_load, pc_value, pc_advance,
                skip_dummy, irq_service}, q.size() > 0 ? q.pop_front() : 40'hx);
        end
    end
    initial begin
        void'($urandom(56138));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4000) step($urandom % 6 != 0, $urandom % 8 != 0);
        repeat (3) step(1'b1, 1'b0);
        chk("pending", 40'(q.size()), 40'h0);
        results();
    end
endmodule
`default_nettype wire
